/* File: hw/lerc_top.v */
`default_nettype none
// Operation
// RULE_01 - exec state acts only in run mode
// RULE_02 - hold: no execution, pc writable only here
// RULE_03 - step: one instruction, pc+1, back to hold
// RULE_04 - free run continues, pc wraps to zero
// RULE_05 - execute once keeps pc unless branch taken
// RULE_06 - ramp or wait completes before hold
// RULE_07 - exec register fields, reset to hold
// RULE_08 - disabled engine: pc zero, no execution
// RULE_09 - memory write only in load, not busy
// RULE_10 - host waits busy clear or 1 ms
// RULE_11 - any load inhibits other engines
// RULE_12 - entering load clears program counter
// RULE_13 - load entered only from disabled
// RULE_14 - run mode executes per exec state
// RULE_15 - halt aborts instruction immediately
// RULE_16 - mode register fields, reset to disabled
// RULE_17 - channel 0 fader source selection
// RULE_18 - channel 0 ratiometric dimming enable
// RULE_19 - channel 0 linear or exponential curve
// RULE_20 - channel 0 charge pump or external supply
`include "lerc_defines.vh"
module lerc_top #(
    parameter PC_W = 8,
    parameter INIT_CYCLES = (`LERC_INIT_US * `LERC_CLK_MHZ)
) (
    input wire clk,
    input wire rst_n,
    input wire clk_en,
    // register port from the serial interface
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    // program memory write request
    input wire mem_wr,
    input wire [1:0] mem_engine,
    output wire [2:0] mem_wr_en,
    output reg mem_reject,
    // instruction executor handshake per engine
    input wire [2:0] instr_done,
    input wire [2:0] instr_branch,
    input wire [3*PC_W-1:0] branch_target,
    output wire [2:0] instr_issue,
    output wire [2:0] instr_abort,
    output wire [3*PC_W-1:0] engine_program_counter,
    // channel 0 controls
    output reg [2:0] chan0_fader_select,
    output reg [1:0] chan0_fader_engine,
    output reg chan0_fader_pwm,
    output reg chan0_ratiometric_on,
    output reg chan0_curve_exponential,
    output reg chan0_supply_external
);
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    reg [7:0] exec_ctrl_reg; // engine_exec_state_ctrl
    reg [7:0] mode_ctrl_reg; // engine_op_mode_ctrl
    reg [7:0] chan0_reg; // channel_zero_ctrl
    wire [2:0] busy;
    wire [2:0] to_hold;
    wire [2:0] any_load_other;
    reg [7:0] mode_next;
    reg [7:0] exec_next;
    // loop index over the three engine fields
    integer i;

    // field extract: engine index 0..2
    function [1:0] fld;
        input [7:0] r;
        input [1:0] e;
        begin
            case (e)
                2'h0: fld = r[`LERC_E1_HI -: 2];
                2'h1: fld = r[`LERC_E2_HI -: 2];
                2'h2: fld = r[`LERC_E3_HI -: 2];
                default: fld = 2'h0;
            endcase
        end
    endfunction

    // ------------------------------------------------------------
    // register write next values
    // ------------------------------------------------------------
    always @* begin
        // without a write the mode register holds its value; an exec field holds unless to_hold sets it to hold
        mode_next = mode_ctrl_reg;
        exec_next = exec_ctrl_reg;
        for (i = 0; i < 3; i = i + 1) begin
            // mode write: load only allowed from disabled
            if (reg_wr && reg_addr == `LERC_ADDR_MODE) begin
                if (fld(reg_wdata, i[1:0]) == `LERC_OM_LOAD &&
                    fld(mode_ctrl_reg, i[1:0]) != `LERC_OM_DIS &&
                    fld(mode_ctrl_reg, i[1:0]) != `LERC_OM_LOAD) begin
                    mode_next[`LERC_E1_HI - 2*i -: 2] = fld(mode_ctrl_reg, i[1:0]); // see RULE_13
                end else begin
                    mode_next[`LERC_E1_HI - 2*i -: 2] = fld(reg_wdata, i[1:0]); // see RULE_16
                end
            end
            // exec write stored in any mode
            if (reg_wr && reg_addr == `LERC_ADDR_EXEC) begin
                exec_next[`LERC_E1_HI - 2*i -: 2] = fld(reg_wdata, i[1:0]); // see RULE_01, RULE_07
            end else if (to_hold[i]) begin
                exec_next[`LERC_E1_HI - 2*i -: 2] = `LERC_EX_HOLD; // see RULE_03, RULE_05
            end
        end
    end

    // ------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (!rst_n) begin
            exec_ctrl_reg <= `LERC_RST_BYTE; // see RULE_07
            mode_ctrl_reg <= `LERC_RST_BYTE; // see RULE_16
            chan0_reg <= `LERC_RST_BYTE;
        end else if (clk_en) begin
            exec_ctrl_reg <= exec_next;
            mode_ctrl_reg <= mode_next;
            // channel 0 byte is stored whole
            if (reg_wr && reg_addr == `LERC_ADDR_CHAN0) begin
                chan0_reg <= reg_wdata;
            end
        end
    end

    // ------------------------------------------------------------
    // engines
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : eng
            // own and neighbour engine indices, cut to the field index width
            localparam [31:0] G_SELF = g;
            localparam [31:0] G_NEXT = (g + 1) % 3;
            localparam [31:0] G_PREV = (g + 2) % 3;
            // another engine in load inhibits this one
            assign any_load_other[g] = (fld(mode_ctrl_reg, G_NEXT[1:0]) == `LERC_OM_LOAD) ||
                                       (fld(mode_ctrl_reg, G_PREV[1:0]) == `LERC_OM_LOAD); // see RULE_11
            lerc_engine #(
                .PC_W(PC_W),
                .INIT_CYCLES(INIT_CYCLES)
            ) u_eng (
                .clk(clk),
                .rst_n(rst_n),
                .clk_en(clk_en),
                .op_mode(fld(mode_ctrl_reg, G_SELF[1:0])),
                .run_state(fld(exec_ctrl_reg, G_SELF[1:0])),
                .inhibit(any_load_other[g]),
                .pc_wr(reg_wr && reg_addr == `LERC_ADDR_PC1 + g),
                .pc_wdata(reg_wdata),
                .instr_done(instr_done[g]),
                .instr_branch(instr_branch[g]),
                .branch_target(branch_target[g*PC_W +: PC_W]),
                .pc_reg(engine_program_counter[g*PC_W +: PC_W]),
                .busy_reg(busy[g]),
                .issue_reg(instr_issue[g]),
                .abort_reg(instr_abort[g]),
                .to_hold(to_hold[g])
            );
            // memory write only in load and not busy
            assign mem_wr_en[g] = mem_wr && (mem_engine == g + 1) &&
                                  (fld(mode_ctrl_reg, G_SELF[1:0]) == `LERC_OM_LOAD) && !busy[g]; // see RULE_09, RULE_10
        end
    endgenerate

    // ------------------------------------------------------------
    // rejected memory writes and read data
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (!rst_n) begin
            mem_reject <= 1'b0;
            reg_rdata <= `LERC_RST_BYTE;
        end else if (clk_en) begin
            // a request that no engine accepts is flagged next cycle
            mem_reject <= mem_wr && (mem_wr_en == 3'h0); // see RULE_09
            if (reg_rd) begin
                case (reg_addr)
                    `LERC_ADDR_EXEC: reg_rdata <= exec_ctrl_reg;
                    `LERC_ADDR_MODE: reg_rdata <= mode_ctrl_reg;
                    `LERC_ADDR_CHAN0: reg_rdata <= chan0_reg;
                    // pc readable only while that engine's exec field is hold, in any mode
                    `LERC_ADDR_PC1: reg_rdata <= (fld(exec_ctrl_reg, 2'h0) == `LERC_EX_HOLD) ?
                        engine_program_counter[PC_W-1:0] : `LERC_RST_BYTE; // see RULE_02
                    `LERC_ADDR_PC2: reg_rdata <= (fld(exec_ctrl_reg, 2'h1) == `LERC_EX_HOLD) ?
                        engine_program_counter[2*PC_W-1:PC_W] : `LERC_RST_BYTE;
                    `LERC_ADDR_PC3: reg_rdata <= (fld(exec_ctrl_reg, 2'h2) == `LERC_EX_HOLD) ?
                        engine_program_counter[3*PC_W-1:2*PC_W] : `LERC_RST_BYTE;
                    `LERC_ADDR_BUSY: reg_rdata <= {5'h00, busy};
                    // unmapped addresses read as zero
                    default: reg_rdata <= `LERC_RST_BYTE;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // channel 0 decode
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (!rst_n) begin
            chan0_fader_select <= `LERC_FADE_NONE;
            chan0_fader_engine <= `LERC_FSEL_NONE;
            chan0_fader_pwm <= 1'b0;
            chan0_ratiometric_on <= 1'b0;
            chan0_curve_exponential <= 1'b0;
            chan0_supply_external <= 1'b0;
        end else if (clk_en) begin
            chan0_fader_select <= chan0_reg[`LERC_FADE_HI:`LERC_FADE_LO];
            // codes 0,4,6,7 mean no fading
            case (chan0_reg[`LERC_FADE_HI:`LERC_FADE_LO])
                `LERC_FADE_E1: chan0_fader_engine <= `LERC_FSEL_E1; // see RULE_17
                `LERC_FADE_E2: chan0_fader_engine <= `LERC_FSEL_E2;
                `LERC_FADE_E3: chan0_fader_engine <= `LERC_FSEL_E3;
                default: chan0_fader_engine <= `LERC_FSEL_NONE;
            endcase
            // pwm input duty as fader source
            chan0_fader_pwm <= (chan0_reg[`LERC_FADE_HI:`LERC_FADE_LO] == `LERC_FADE_PWM); // see RULE_17
            chan0_ratiometric_on <= chan0_reg[`LERC_RATIO_BIT]; // see RULE_18
            chan0_curve_exponential <= chan0_reg[`LERC_EXP_BIT]; // see RULE_19
            chan0_supply_external <= chan0_reg[`LERC_EXT_BIT]; // see RULE_20
        end
    end
endmodule
`default_nettype wire

/* File: pkg/lerc_defines.vh */
// ------------------------------------------------------------
// register map and field constants
// ------------------------------------------------------------
`ifndef LERC_DEFINES_VH
`define LERC_DEFINES_VH

// register offsets
`define LERC_ADDR_EXEC 8'h01
`define LERC_ADDR_MODE 8'h02
`define LERC_ADDR_CHAN0 8'h07
`define LERC_ADDR_PC1 8'h30
`define LERC_ADDR_PC2 8'h31
`define LERC_ADDR_PC3 8'h32
`define LERC_ADDR_BUSY 8'h3C

// reset values
`define LERC_RST_BYTE 8'h00
`define LERC_RST_PC 8'h00
`define LERC_PC_LAST 8'hFF

// execution states
`define LERC_EX_HOLD 2'h0
`define LERC_EX_STEP 2'h1
`define LERC_EX_FREE 2'h2
`define LERC_EX_ONCE 2'h3

// operation modes
`define LERC_OM_DIS 2'h0
`define LERC_OM_LOAD 2'h1
`define LERC_OM_RUN 2'h2
`define LERC_OM_HALT 2'h3

// field positions: engine n field high bit is 9-2n
`define LERC_E1_HI 7
`define LERC_E2_HI 5
`define LERC_E3_HI 3

// channel 0 fields
`define LERC_FADE_HI 7
`define LERC_FADE_LO 5
`define LERC_RATIO_BIT 4
`define LERC_EXP_BIT 3
`define LERC_EXT_BIT 2
`define LERC_FADE_NONE 3'h0
`define LERC_FADE_E1 3'h1
`define LERC_FADE_E2 3'h2
`define LERC_FADE_E3 3'h3
`define LERC_FADE_PWM 3'h5
`define LERC_FSEL_NONE 2'h0
`define LERC_FSEL_E1 2'h1
`define LERC_FSEL_E2 2'h2
`define LERC_FSEL_E3 2'h3

// load-mode initialisation time
`define LERC_INIT_US 1000
`define LERC_CLK_MHZ 250

`endif

/* File: hw/lerc_engine.v */
`default_nettype none
// ------------------------------------------------------------
// one program engine: pc and instruction sequencing
// ------------------------------------------------------------
`include "lerc_defines.vh"
module lerc_engine #(
    parameter PC_W = 8,
    parameter INIT_CYCLES = 250000
) (
    input wire clk,
    input wire rst_n,
    input wire clk_en,
    input wire [1:0] op_mode,
    input wire [1:0] run_state,
    input wire inhibit,
    input wire pc_wr,
    input wire [7:0] pc_wdata,
    input wire instr_done,
    input wire instr_branch,
    input wire [PC_W-1:0] branch_target,
    output reg [PC_W-1:0] pc_reg,
    output reg busy_reg,
    output reg issue_reg,
    output reg abort_reg,
    output wire to_hold
);
    // instruction in flight flag
    reg active_reg;
    // load initialisation counter
    reg [31:0] init_cnt_reg;
    reg [1:0] prev_mode_reg;
    // single-instruction states that return to hold
    wire single = (run_state == `LERC_EX_STEP) || (run_state == `LERC_EX_ONCE);
    // engine may run this cycle
    wire may_run = (op_mode == `LERC_OM_RUN) && !inhibit; // see RULE_01, RULE_11, RULE_14
    wire wants = may_run && (run_state != `LERC_EX_HOLD); // see RULE_02
    // hold request once the single instruction fully completes
    assign to_hold = may_run && single && active_reg && instr_done; // see RULE_03, RULE_05, RULE_06

    // ------------------------------------------------------------
    // sequencing
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (!rst_n) begin
            pc_reg <= `LERC_RST_PC;
            busy_reg <= 1'b0;
            issue_reg <= 1'b0;
            abort_reg <= 1'b0;
            active_reg <= 1'b0;
            init_cnt_reg <= 32'h0;
            prev_mode_reg <= `LERC_OM_DIS;
        end else if (clk_en) begin
            prev_mode_reg <= op_mode;
            issue_reg <= 1'b0;
            abort_reg <= 1'b0;
            // busy counts down after entering load
            if (op_mode == `LERC_OM_LOAD && prev_mode_reg != `LERC_OM_LOAD) begin
                busy_reg <= 1'b1;
                init_cnt_reg <= INIT_CYCLES;
            end else if (init_cnt_reg != 32'h0) begin
                init_cnt_reg <= init_cnt_reg - 32'h1;
            end else begin
                busy_reg <= 1'b0;
            end
            if (op_mode == `LERC_OM_DIS) begin
                // disabled: pc forced to zero, nothing runs
                pc_reg <= `LERC_RST_PC; // see RULE_08
                active_reg <= 1'b0;
            end else if (op_mode == `LERC_OM_LOAD) begin
                pc_reg <= `LERC_RST_PC; // see RULE_12
                active_reg <= 1'b0;
            end else if (op_mode == `LERC_OM_HALT) begin
                // abort any instruction at once
                abort_reg <= active_reg; // see RULE_15
                active_reg <= 1'b0;
            end else if (!may_run || run_state == `LERC_EX_HOLD) begin
                // hold: pc only changes by host write
                if (pc_wr && may_run) begin
                    pc_reg <= pc_wdata[PC_W-1:0]; // see RULE_02
                end
                active_reg <= 1'b0;
            end else if (!active_reg) begin
                // launch an instruction
                issue_reg <= wants;
                active_reg <= wants;
            end else if (instr_done) begin
                active_reg <= 1'b0;
                if (run_state == `LERC_EX_ONCE) begin
                    // pc kept unless a branch was taken
                    if (instr_branch) begin
                        pc_reg <= branch_target; // see RULE_05
                    end
                end else if (instr_branch) begin
                    pc_reg <= branch_target;
                end else begin
                    // step and free run advance, wrapping at the top
                    pc_reg <= pc_reg + {{(PC_W-1){1'b0}}, 1'b1}; // see RULE_03, RULE_04
                end
            end
        end
    end
endmodule
`default_nettype wire

/* File: sim/lerc_top_asserts.sv */
`default_nettype none
// ------------------------------------------------------------
// checker on the ports of the run-control top
// ------------------------------------------------------------
module lerc_top_asserts #(
    parameter PC_W = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic mem_wr,
    input wire logic [1:0] mem_engine,
    input wire logic [2:0] mem_wr_en,
    input wire logic mem_reject,
    input wire logic [2:0] instr_issue,
    input wire logic [3*PC_W-1:0] engine_program_counter,
    input wire logic [2:0] chan0_fader_select,
    input wire logic [1:0] chan0_fader_engine,
    input wire logic chan0_fader_pwm,
    input wire logic chan0_ratiometric_on,
    input wire logic chan0_supply_external
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] ch0_reg; // shadow of the channel 0 register
    logic [7:0] ch0_late_reg; // shadow one cycle later, as the decodes lag by one
    logic mode_wr; // a mode register write is taken
    assign mode_wr = clk_en && reg_wr && reg_addr == 8'h02;
    // track channel 0 writes, frozen with the rest when clk_en is low
    always @(posedge clk) begin
        if (!rst_n) begin
            ch0_reg <= 8'h00;
            ch0_late_reg <= 8'h00;
        end else if (clk_en) begin
            if (reg_wr && reg_addr == 8'h07) begin
                ch0_reg <= reg_wdata;
            end
            ch0_late_reg <= ch0_reg;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_fader_decode: assert property (chan0_fader_select == ch0_late_reg[7:5]
        && chan0_fader_pwm == (ch0_late_reg[7:5] == 3'h5) && chan0_fader_engine ==
        ((ch0_late_reg[7:5] inside {3'h1, 3'h2, 3'h3}) ? ch0_late_reg[6:5] : 2'h0)) else $error("fader decode wrong");
    a_ratio_bit: assert property (chan0_ratiometric_on == ch0_late_reg[4]) else $error("ratio bit wrong");
    a_supply_bit: assert property (chan0_supply_external == ch0_late_reg[2]) else $error("supply bit wrong");
    a_chan0_read: assert property (clk_en && reg_rd && !reg_wr && reg_addr == 8'h07 |=>
        reg_rdata == $past(ch0_reg)) else $error("channel 0 readback wrong");
    a_mem_onehot: assert property (mem_wr_en != 3'h0 |-> mem_wr
        && mem_wr_en == (3'h1 << (mem_engine - 2'h1))) else $error("write enable without matching request");
    a_mem_refuse: assert property (clk_en && mem_wr && mem_engine != 2'h0 && mem_wr_en == 3'h0
        |=> mem_reject) else $error("refused write not flagged");
    a_reject_cause: assert property (mem_reject |-> $past(mem_wr) && $past(mem_wr_en) == 3'h0)
        else $error("reject without refused write");
    a_halt_stops: assert property (mode_wr && reg_wdata[7:6] == 2'h3 ##1 clk_en && !mode_wr
        |=> !instr_issue[0]) else $error("issue after halt");
    a_disable_pc: assert property (mode_wr && reg_wdata[7:6] == 2'h0 ##1 clk_en && !mode_wr
        |=> engine_program_counter[PC_W-1:0] == '0) else $error("pc not zero when disabled");
    c_halt: cover property (mode_wr && reg_wdata[7:6] == 2'h3);
    c_reject: cover property (mem_reject);
    c_pwm: cover property (chan0_fader_pwm);
endmodule
`default_nettype wire

/* File: sim/lerc_exec_model.sv */
`default_nettype none
// ------------------------------------------------------------
// instruction executor beside the three engines
// ------------------------------------------------------------
module lerc_exec_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [2:0] instr_issue,
    input wire logic [2:0] instr_abort,
    input wire logic [7:0] dly,
    input wire logic br_take,
    output logic [2:0] instr_done,
    output logic [2:0] instr_branch,
    output logic [23:0] branch_target
);
    timeunit 1ns;
    timeprecision 1ps;
    int left_cnt[3]; // cycles until the running instruction ends
    assign branch_target = {3{8'h20}}; // fixed jump target for every engine
    // each instruction lasts dly cycles like a ramp or wait; abort drops it
    always @(posedge clk) begin
        for (int i = 0; i < 3; i++) begin
            instr_done[i] <= 1'b0;
            instr_branch[i] <= ~instr_branch[i]; // meaningless outside done, so keep it moving
            if (!rst_n) begin
                left_cnt[i] <= 0;
                instr_branch[i] <= 1'b0;
            end else if (instr_abort[i]) begin
                left_cnt[i] <= 0;
            end else if (instr_issue[i]) begin
                left_cnt[i] <= dly;
            end else if (left_cnt[i] == 1) begin
                left_cnt[i] <= 0;
                instr_done[i] <= 1'b1;
                instr_branch[i] <= br_take;
            end else if (left_cnt[i] > 1) begin
                left_cnt[i] <= left_cnt[i] - 1;
            end
        end
    end
endmodule
`default_nettype wire

/* File: sim/tb_top.sv */
`default_nettype none
// ------------------------------------------------------------
// bench top: register tasks and directed sequences
// ------------------------------------------------------------
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int INIT = 8; // shortened load initialisation
    logic clk, rst_n, clk_en, reg_wr, reg_rd, mem_wr, mem_reject, br_take, fpwm, fratio, fcurve, fext;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, dly, d;
    logic [1:0] mem_engine, feng;
    logic [2:0] mem_wr_en, instr_done, instr_branch, instr_issue, instr_abort, fsel;
    logic [23:0] branch_target, pc_bus;
    int fails = 0, samples_checked = 0, cycles = 0, iss0 = 0, iss1 = 0, abort0 = 0, n;
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    lerc_top #(.PC_W(8), .INIT_CYCLES(INIT)) dut_u (.clk(clk), .rst_n(rst_n), .clk_en(clk_en),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .mem_wr(mem_wr), .mem_engine(mem_engine), .mem_wr_en(mem_wr_en), .mem_reject(mem_reject),
        .instr_done(instr_done), .instr_branch(instr_branch), .branch_target(branch_target),
        .instr_issue(instr_issue), .instr_abort(instr_abort), .engine_program_counter(pc_bus),
        .chan0_fader_select(fsel), .chan0_fader_engine(feng), .chan0_fader_pwm(fpwm),
        .chan0_ratiometric_on(fratio), .chan0_curve_exponential(fcurve), .chan0_supply_external(fext));
    lerc_exec_model exec_u (.clk(clk), .rst_n(rst_n), .instr_issue(instr_issue), .instr_abort(instr_abort),
        .dly(dly), .br_take(br_take), .instr_done(instr_done), .instr_branch(instr_branch),
        .branch_target(branch_target));
    // count issues and aborts, and cut a hang short
    always @(posedge clk) begin
        cycles <= cycles + 1;
        iss0 <= iss0 + instr_issue[0];
        iss1 <= iss1 + instr_issue[1];
        abort0 <= abort0 + instr_abort[0];
        if (cycles == 20000) begin
            fails++;
            $display("mismatch at %0t: timeout", $time);
            summarize();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask
    // program memory request: accept seen at once, refusal one cycle later
    task automatic mw(input logic [1:0] e, input logic [2:0] ok);
        @(posedge clk);
        mem_wr <= 1'b1;
        mem_engine <= e;
        #1;
        chk({5'h00, mem_wr_en}, {5'h00, ok});
        @(posedge clk);
        mem_wr <= 1'b0;
        #1;
        chk({7'h00, mem_reject}, {7'h00, ok == 3'h0});
    endtask
    task automatic wait_pc(input logic [7:0] t);
        for (int i = 0; i < 200 && pc_bus[7:0] !== t; i++) begin
            @(posedge clk);
        end
        #1;
        chk(pc_bus[7:0], t);
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {rst_n, reg_wr, reg_rd, mem_wr, br_take, reg_addr, reg_wdata, mem_engine} = '0;
        clk_en = 1'b1;
        dly = 8'h0C;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        rd(8'h01, 8'h00);
        rd(8'h02, 8'h00);
        rd(8'h07, 8'h00);
        wr(8'h02, 8'h03);
        rd(8'h02, 8'h00);
        wr(8'h01, 8'hFF);
        rd(8'h01, 8'hFC);
        // every fader code, with the single-bit fields varied
        for (int c = 0; c < 8; c++) begin
            d = {c[2:0], c[0], c[1], ~c[0], 2'b00};
            wr(8'h07, d);
            rd(8'h07, d);
            chk({fsel, feng, fpwm, fratio, fcurve}, {c[2:0], (c >= 1 && c <= 3) ? c[1:0] : 2'b00, c == 5, d[4:3]});
            chk({7'h00, fext}, {7'h00, d[2]});
        end
        // a write with the clock enable low must not land
        clk_en <= 1'b0;
        wr(8'h07, 8'h00);
        clk_en <= 1'b1;
        rd(8'h07, 8'hF8);
        wr(8'h01, 8'h00);
        wr(8'h02, 8'h40);
        rd(8'h3C, 8'h01);
        chk(pc_bus[7:0], 8'h00);
        mw(2'd1, 3'h0);
        repeat (INIT) @(posedge clk); // host lets initialisation finish
        mw(2'd1, 3'h1);
        mw(2'd2, 3'h0);
        wr(8'h02, 8'h60);
        wr(8'h01, 8'h20);
        repeat (10) @(posedge clk);
        chk(iss1[7:0], 8'h00);
        wr(8'h02, 8'h00);
        wr(8'h01, 8'h40);
        repeat (8) @(posedge clk);
        chk(iss0[7:0], 8'h00);
        wr(8'h02, 8'h80);
        repeat (4) @(posedge clk);
        rd(8'h01, 8'h40);
        wait_pc(8'h01);
        rd(8'h01, 8'h00);
        wr(8'h02, 8'h40);
        rd(8'h02, 8'h80);
        wr(8'h30, 8'h10);
        rd(8'h30, 8'h10);
        wr(8'h01, 8'hC0);
        repeat (20) @(posedge clk);
        chk(pc_bus[7:0], 8'h10);
        rd(8'h01, 8'h00);
        br_take <= 1'b1;
        wr(8'h01, 8'hC0);
        wait_pc(8'h20);
        br_take <= 1'b0;
        dly <= 8'h01;
        wr(8'h30, 8'hFE);
        wr(8'h01, 8'h80);
        wait_pc(8'h00);
        dly <= 8'h0C;
        wait_pc(8'h02);
        wr(8'h02, 8'hC0);
        n = iss0;
        repeat (30) @(posedge clk);
        chk(abort0[7:0], 8'h01);
        chk(iss0[7:0], n[7:0]);
        wr(8'h02, 8'h00);
        repeat (2) @(posedge clk);
        #1;
        chk(pc_bus[7:0], 8'h00);
        summarize();
    end
endmodule
bind lerc_top lerc_top_asserts #(.PC_W(PC_W)) chk_u (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .mem_wr(mem_wr),
    .mem_engine(mem_engine), .mem_wr_en(mem_wr_en), .mem_reject(mem_reject), .instr_issue(instr_issue),
    .engine_program_counter(engine_program_counter), .chan0_fader_select(chan0_fader_select),
    .chan0_fader_engine(chan0_fader_engine), .chan0_fader_pwm(chan0_fader_pwm),
    .chan0_ratiometric_on(chan0_ratiometric_on), .chan0_supply_external(chan0_supply_external));
`default_nettype wire
